// *** design/lin_io_slave_mode_control.sv ***
`include "lin_io_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lin_io_slave_mode_control
#(
    parameter int DOM_TIMEOUT_CYCLES  = 10000,
    parameter int IDLE_TIMEOUT_CYCLES = 100000,
    parameter int CYCLIC_DIV          = `CYCLIC_DIV_DEFAULT
)
(
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        clk_en_in,
    input  wire logic [5:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        lin_rx_in,
    input  wire logic [7:0]  io_pin_in,
    input  wire logic [7:0]  matrix_value_in,
    input  wire logic [7:0]  adc_sample_in,
    output logic [7:0]       io_pin_out,
    output logic [7:0]       io_pin_oe_out,
    output logic             regulator_control_pin_out,
    output logic             regulator_control_pin_oe_out,
    output logic             bus_wake_out,
    output logic             adc_reset_out,
    output logic             adc_start_out,
    output logic             matrix_scan_out,
    output logic [2:0]       mode_out
);

    // =====================================================================
    // Bus slave
    // =====================================================================
    logic        rd_pend_q;
    logic [7:0]  byte_addr;
    logic        wr_acc;
    logic        rd_acc;
    logic [15:0] ev;
    logic [31:0] rd_d;

    assign byte_addr = {avs_address_in, 2'b00};
    // Writes finish at once; reads answer one cycle later from a register.
    assign avs_waitrequest_out = avs_read_in & ~rd_pend_q;
    assign wr_acc = avs_write_in & clk_en_in;
    assign rd_acc = avs_read_in & rd_pend_q & clk_en_in;
    assign ev = (wr_acc && byte_addr == `REG_EVENT && avs_byteenable_in[1:0] != 2'b00)
                ? avs_writedata_in[15:0] : 16'h0000;

    // =====================================================================
    // State
    // =====================================================================
    lin_io_pkg::op_mode_t mode_q;
    logic [5:0]  cfg_q;
    logic        configured_q;
    logic        io_active_q;
    logic [7:0]  fallback_q;
    logic [7:0]  pwm_q;
    logic [7:0]  hse_q;
    logic [7:0]  lse_q;
    logic [7:0]  om_lo_q;
    logic [7:0]  om_hi_q;
    logic [7:0]  latch_q;
    logic [7:0]  diag_q;
    logic [7:0]  matrix_q;
    logic [7:0]  adc_q;
    logic        scan_pend_q;
    logic [7:0]  pwm_cnt_q;
    logic [15:0] cyc_cnt_q;
    logic        cyc_phase_q;
    logic [31:0] dom_cnt_q;
    logic [31:0] idle_cnt_q;
    logic        dom_to;
    logic        idle_to;
    logic        low_power;
    logic        in_config;
    logic        sleepish;
    logic [7:0]  pwm_pins;
    logic [7:0]  cyc_pins;
    logic        matrix_change;

    function automatic logic is_wr(input logic [7:0] a);
        is_wr = wr_acc && byte_addr == a && avs_byteenable_in[0];
    endfunction

    assign low_power = mode_q == lin_io_pkg::MODE_SLEEP
                    || mode_q == lin_io_pkg::MODE_FALLBACK_SLEEP
                    || mode_q == lin_io_pkg::MODE_FALLBACK;
    assign sleepish  = mode_q == lin_io_pkg::MODE_SLEEP
                    || mode_q == lin_io_pkg::MODE_FALLBACK_SLEEP;
    assign in_config = mode_q == lin_io_pkg::MODE_CONFIG;
    assign pwm_pins  = om_lo_q & om_hi_q;
    assign cyc_pins  = om_hi_q & ~om_lo_q & hse_q & ~lse_q;
    assign dom_to    = dom_cnt_q >= 32'(DOM_TIMEOUT_CYCLES);
    assign idle_to   = idle_cnt_q >= 32'(IDLE_TIMEOUT_CYCLES);
    assign matrix_change = cfg_q[`CFG_MATRIX_EN] && matrix_value_in != matrix_q;

    // Bus timeout counters run only while the bus watch is meaningful.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            dom_cnt_q  <= 32'h0000_0000;
            idle_cnt_q <= 32'h0000_0000;
        end
        else if (clk_en_in)
        begin
            if (lin_rx_in || low_power)
                dom_cnt_q <= 32'h0000_0000;
            else if (!dom_to)
                dom_cnt_q <= dom_cnt_q + 32'h0000_0001;
            if (ev[`EV_BUS_ACTIVITY] || low_power)
                idle_cnt_q <= 32'h0000_0000;
            else if (!idle_to)
                idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
        end
    end

    // Mode state machine; the CFG_SLEEP_FALLBACK bit decides which sleep to enter.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            mode_q <= lin_io_pkg::MODE_CONFIG;
        else if (clk_en_in)
        begin
            case (mode_q)
                lin_io_pkg::MODE_CONFIG:
                    if (dom_to || idle_to || ev[`EV_SLEEP_CMD] || ev[`EV_CONFIG_FAIL])
                        mode_q <= lin_io_pkg::MODE_FALLBACK;
                    else if (ev[`EV_NAD_ASSIGN] || ev[`EV_DEFAULT_NAD_USE])
                        mode_q <= lin_io_pkg::MODE_NORMAL;
                lin_io_pkg::MODE_NORMAL:
                    if (dom_to || idle_to)
                        mode_q <= lin_io_pkg::MODE_FALLBACK;
                    else if (ev[`EV_SLEEP_CMD])
                        mode_q <= cfg_q[`CFG_SLEEP_FALLBACK]
                                  ? lin_io_pkg::MODE_FALLBACK_SLEEP
                                  : lin_io_pkg::MODE_SLEEP;
                lin_io_pkg::MODE_SLEEP,
                lin_io_pkg::MODE_FALLBACK_SLEEP:
                    if (ev[`EV_LOCAL_WAKE] || ev[`EV_REMOTE_WAKE]
                        || (matrix_change && cfg_q[`CFG_MATRIX_WAKE]))
                        mode_q <= lin_io_pkg::MODE_NORMAL;
                lin_io_pkg::MODE_FALLBACK:
                    if (ev[`EV_REMOTE_WAKE])
                        mode_q <= configured_q ? lin_io_pkg::MODE_STANDBY
                                               : lin_io_pkg::MODE_CONFIG;
                lin_io_pkg::MODE_STANDBY:
                    if (ev[`EV_SLEEP_CMD] || ev[`EV_CONFIG_FAIL])
                        mode_q <= lin_io_pkg::MODE_FALLBACK;
                    else if (ev[`EV_SLAVE_RESP_READ])
                        mode_q <= lin_io_pkg::MODE_NORMAL;
                default:
                    mode_q <= lin_io_pkg::MODE_CONFIG;
            endcase
        end
    end

    // Configured status and I/O activation; software config writes are
    // refused in configuration mode, only the master request path counts.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            configured_q <= 1'b0;
            io_active_q  <= 1'b0;
            cfg_q        <= 6'h00;
        end
        else if (clk_en_in)
        begin
            if (ev[`EV_NAD_ASSIGN] || ev[`EV_DEFAULT_NAD_USE])
                configured_q <= 1'b1;
            if (ev[`EV_PORT_FRAME] && !in_config)
                io_active_q <= 1'b1;
            if (is_wr(`REG_CONFIG) && (!in_config || ev[`EV_MASTER_REQ]))
                cfg_q <= avs_writedata_in[5:0];
        end
    end

    // Pin configuration; reassigning the node address turns outputs off.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            hse_q      <= 8'h00;
            lse_q      <= 8'h00;
            om_lo_q    <= 8'h00;
            om_hi_q    <= 8'h00;
            fallback_q <= 8'h00;
        end
        else if (clk_en_in)
        begin
            if (ev[`EV_NAD_ASSIGN] && configured_q)
            begin
                hse_q <= 8'h00;
                lse_q <= 8'h00;
            end
            else if (!in_config || ev[`EV_MASTER_REQ])
            begin
                if (is_wr(`REG_PIN_HIGH_EN))
                    hse_q <= avs_writedata_in[7:0];
                if (is_wr(`REG_PIN_LOW_EN))
                    lse_q <= avs_writedata_in[7:0];
            end
            if (is_wr(`REG_PIN_MODE_LOW) && (!in_config || ev[`EV_MASTER_REQ]))
                om_lo_q <= avs_writedata_in[7:0];
            if (is_wr(`REG_PIN_MODE_HIGH) && (!in_config || ev[`EV_MASTER_REQ]))
                om_hi_q <= avs_writedata_in[7:0];
            if (is_wr(`REG_FALLBACK_VALUE) && (!in_config || ev[`EV_MASTER_REQ]))
                fallback_q <= avs_writedata_in[7:0];
        end
    end

    // Output latches: fallback value loaded on fallback entries from normal mode, kept after wake.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            latch_q <= 8'h00;
        else if (clk_en_in)
        begin
            if (mode_q == lin_io_pkg::MODE_NORMAL && ev[`EV_SLEEP_CMD] && !dom_to && !idle_to
                && cfg_q[`CFG_SLEEP_FALLBACK])
                latch_q <= fallback_q;
            else if (mode_q == lin_io_pkg::MODE_NORMAL && (dom_to || idle_to))
                latch_q <= fallback_q;
            else if (is_wr(`REG_OUT_LATCH) && mode_q == lin_io_pkg::MODE_NORMAL)
                latch_q <= (avs_writedata_in[7:0] & ~pwm_pins & ~cyc_pins)
                         | (latch_q & (pwm_pins | cyc_pins));
            else if (cyc_cnt_q == 16'(CYCLIC_DIV - 1))
                latch_q <= (latch_q & ~cyc_pins) | ({8{~cyc_phase_q}} & cyc_pins);
        end
    end

    // Cyclic-sense timer shared by all such pins so they sample together.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cyc_cnt_q   <= 16'h0000;
            cyc_phase_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (cyc_cnt_q == 16'(CYCLIC_DIV - 1))
            begin
                cyc_cnt_q   <= 16'h0000;
                cyc_phase_q <= ~cyc_phase_q;
            end
            else
                cyc_cnt_q <= cyc_cnt_q + 16'h0001;
        end
    end

    // PWM value, cleared in every low-power mode, and free-running 256-step counter.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pwm_q     <= `PWM_RESET_VALUE;
            pwm_cnt_q <= 8'h00;
        end
        else if (clk_en_in)
        begin
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
            if (low_power)
                pwm_q <= `PWM_RESET_VALUE;
            else if (is_wr(`REG_PWM_VALUE) && !in_config)
                pwm_q <= avs_writedata_in[7:0];
        end
    end

    // Diagnostics, matrix capture and ADC; set wins over read-clear.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            diag_q      <= 8'h00;
            matrix_q    <= 8'h00;
            adc_q       <= 8'h00;
            scan_pend_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (rd_acc && byte_addr == `REG_DIAG)
                diag_q <= 8'h00;
            if (((dom_to || idle_to) && (in_config || mode_q == lin_io_pkg::MODE_NORMAL))
                || ((ev[`EV_CONFIG_FAIL] || ev[`EV_SLEEP_CMD])
                && (in_config || mode_q == lin_io_pkg::MODE_STANDBY)))
                diag_q[`DIAG_FALLBACK_BIT] <= 1'b1;
            if (ev[`EV_BREAK_SYNC] && ev[`EV_ADDRESSED])
                scan_pend_q <= 1'b1;
            else if (ev[`EV_MSG_DONE])
                scan_pend_q <= 1'b0;
            if (matrix_change && (!cfg_q[`CFG_MATRIX_CAPTURE]
                || (rd_acc && byte_addr == `REG_MATRIX) || ev[`EV_PORT_RESP_READ]))
                matrix_q <= matrix_value_in;
            if (low_power)
                adc_q <= 8'h00;
            else if (ev[`EV_BREAK_SYNC])
                adc_q <= adc_sample_in;
        end
    end

    // Pulses and pin drive outputs.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            adc_start_out   <= 1'b0;
            matrix_scan_out <= 1'b0;
            bus_wake_out    <= 1'b0;
            io_pin_out      <= 8'h00;
            io_pin_oe_out   <= 8'h00;
            regulator_control_pin_out    <= 1'b1;
            regulator_control_pin_oe_out <= 1'b1;
        end
        else if (clk_en_in)
        begin
            adc_start_out   <= ev[`EV_BREAK_SYNC] && !low_power;
            matrix_scan_out <= cfg_q[`CFG_MATRIX_EN] && mode_q == lin_io_pkg::MODE_NORMAL
                && ((ev[`EV_BREAK_SYNC] && !ev[`EV_ADDRESSED])
                || (scan_pend_q && ev[`EV_MSG_DONE]));
            bus_wake_out    <= sleepish && ev[`EV_LOCAL_WAKE];
            io_pin_out      <= (latch_q & ~pwm_pins)
                             | (pwm_pins & {8{pwm_cnt_q < pwm_q}});
            io_pin_oe_out   <= io_active_q ? (hse_q | lse_q) : 8'h00;
            regulator_control_pin_out <= 1'b1;
            regulator_control_pin_oe_out <= (cfg_q[1:0] != 2'b00) || !low_power;
        end
    end

    assign adc_reset_out = low_power;
    assign mode_out = mode_q;

    // Read mux, registered.
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (byte_addr)
            `REG_MODE_STATUS:    rd_d = {27'h0, io_active_q, configured_q, mode_q};
            `REG_CONFIG:         rd_d = {26'h0, cfg_q};
            `REG_FALLBACK_VALUE: rd_d = {24'h0, fallback_q};
            `REG_PWM_VALUE:      rd_d = {24'h0, pwm_q};
            `REG_PIN_HIGH_EN:    rd_d = {24'h0, hse_q};
            `REG_PIN_LOW_EN:     rd_d = {24'h0, lse_q};
            `REG_PIN_MODE_LOW:   rd_d = {24'h0, om_lo_q};
            `REG_PIN_MODE_HIGH:  rd_d = {24'h0, om_hi_q};
            `REG_OUT_LATCH:      rd_d = {16'h0, io_pin_in, latch_q};
            `REG_DIAG:           rd_d = {24'h0, diag_q};
            `REG_MATRIX:         rd_d = {24'h0, matrix_q};
            `REG_ADC:            rd_d = {24'h0, adc_q};
            default:             rd_d = 32'h0000_0000;
        endcase
    end

    // A read waits one cycle, then data is held with waitrequest low.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_pend_q        <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end
        else if (clk_en_in)
        begin
            rd_pend_q <= avs_read_in && !rd_pend_q;
            if (avs_read_in && !rd_pend_q)
                avs_readdata_out <= rd_d;
        end
    end

endmodule

`default_nettype wire

// *** design/lin_io_consts.svh ***
`ifndef LIN_IO_CONSTS_SVH
`define LIN_IO_CONSTS_SVH

// Avalon register byte offsets.
`define REG_MODE_STATUS     8'h00
`define REG_CONFIG          8'h04
`define REG_EVENT           8'h08
`define REG_FALLBACK_VALUE  8'h0C
`define REG_PWM_VALUE       8'h10
`define REG_PIN_HIGH_EN     8'h14
`define REG_PIN_LOW_EN      8'h18
`define REG_PIN_MODE_LOW    8'h1C
`define REG_PIN_MODE_HIGH   8'h20
`define REG_OUT_LATCH       8'h24
`define REG_DIAG            8'h28
`define REG_MATRIX          8'h2C
`define REG_ADC             8'h30

// Config register fields.
`define CFG_REG_FN_LOW      0
`define CFG_REG_FN_HIGH     1
`define CFG_MATRIX_WAKE     2
`define CFG_MATRIX_CAPTURE  3
`define CFG_MATRIX_EN       4
`define CFG_SLEEP_FALLBACK  5

// Event register bits (write one to pulse).
`define EV_NAD_ASSIGN       0
`define EV_DEFAULT_NAD_USE  1
`define EV_MASTER_REQ       2
`define EV_SLEEP_CMD        3
`define EV_SLAVE_RESP_READ  4
`define EV_CONFIG_FAIL      5
`define EV_PORT_FRAME       6
`define EV_REMOTE_WAKE      7
`define EV_BREAK_SYNC       8
`define EV_ADDRESSED        9
`define EV_MSG_DONE         10
`define EV_PORT_RESP_READ   11
`define EV_LOCAL_WAKE       12
`define EV_BUS_ACTIVITY     13

// Diagnostic flag position and PWM reset value.
`define DIAG_FALLBACK_BIT   1
`define PWM_RESET_VALUE     8'h00
`define CYCLIC_DIV_DEFAULT  1024
`define PWM_PRESCALE        1

`endif

// *** design/lin_io_pkg.sv ***
package lin_io_pkg;
    typedef enum logic [2:0]
    {
        MODE_CONFIG         = 3'b000,
        MODE_NORMAL         = 3'b001,
        MODE_SLEEP          = 3'b010,
        MODE_FALLBACK_SLEEP = 3'b011,
        MODE_FALLBACK       = 3'b100,
        MODE_STANDBY        = 3'b101
    } op_mode_t;
endpackage

// *** dv/lin_io_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker for the mode controller.
module lin_io_chk
#(
    parameter int DOM_TIMEOUT_CYCLES = 20
)
(
    input wire logic        sys_clk_in,
    input wire logic        nrst_in,
    input wire logic [5:0]  avs_address_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic        avs_waitrequest_out,
    input wire logic        lin_rx_in,
    input wire logic [7:0]  io_pin_oe_out,
    input wire logic        regulator_control_pin_out,
    input wire logic        regulator_control_pin_oe_out,
    input wire logic        bus_wake_out,
    input wire logic        adc_reset_out,
    input wire logic        adc_start_out,
    input wire logic [2:0]  mode_out
);
    logic [15:0] dom_q;
    wire         ev = avs_write_in && avs_address_in == 6'h02 && !avs_waitrequest_out;
    wire [31:0]  d = avs_writedata_in;
    wire [2:0]   m = mode_out;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // Dominant cycles seen in normal mode; a stuck counter would hide a short to ground.
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            dom_q <= 16'h0000;
        else if (!lin_rx_in && m == lin_io_pkg::MODE_NORMAL)
            dom_q <= dom_q + 16'h0001;
        else
            dom_q <= 16'h0000;
    end
    a_reset_config:
    assert property ($rose(nrst_in) |-> m == lin_io_pkg::MODE_CONFIG && io_pin_oe_out == 8'h00)
        else $error("reset state wrong");
    a_nad_normal:
    assert property (ev && d[0] && m == lin_io_pkg::MODE_CONFIG |=> m == lin_io_pkg::MODE_NORMAL)
        else $error("no normal after address");
    a_nad_hiz:
    assert property (ev && d[0] && m == lin_io_pkg::MODE_NORMAL |=> ##1 io_pin_oe_out == 8'h00)
        else $error("outputs kept after readdress");
    a_sleep_enter:
    assert property (ev && d[3] && m == lin_io_pkg::MODE_NORMAL |=> m inside
        {lin_io_pkg::MODE_SLEEP, lin_io_pkg::MODE_FALLBACK_SLEEP}) else $error("no sleep");
    a_wake_signal:
    assert property (ev && d[12] && m inside {lin_io_pkg::MODE_SLEEP,
        lin_io_pkg::MODE_FALLBACK_SLEEP} |=> m == lin_io_pkg::MODE_NORMAL && bus_wake_out
        ##1 !bus_wake_out) else $error("wake wrong");
    a_low_adc:
    assert property (m inside {lin_io_pkg::MODE_SLEEP, lin_io_pkg::MODE_FALLBACK_SLEEP,
        lin_io_pkg::MODE_FALLBACK} |-> adc_reset_out) else $error("adc not reset");
    a_reg_high:
    assert property ($stable(mode_out) && m inside {lin_io_pkg::MODE_CONFIG,
        lin_io_pkg::MODE_NORMAL, lin_io_pkg::MODE_STANDBY} |-> regulator_control_pin_out
        && regulator_control_pin_oe_out) else $error("regulator pin not high");
    a_dom_limit:
    assert property (dom_q <= DOM_TIMEOUT_CYCLES + 2) else $error("dominant timeout missed");
    a_fb_wake:
    assert property (ev && d[7] && m == lin_io_pkg::MODE_FALLBACK |=> m inside
        {lin_io_pkg::MODE_STANDBY, lin_io_pkg::MODE_CONFIG}) else $error("fallback wake wrong");
    a_stby_normal:
    assert property (ev && d[4] && m == lin_io_pkg::MODE_STANDBY |=> m == lin_io_pkg::MODE_NORMAL)
        else $error("standby stuck");
    a_adc_start:
    assert property (ev && d[8] && m == lin_io_pkg::MODE_NORMAL |=> adc_start_out
        ##1 !adc_start_out) else $error("adc start wrong");
    c_fb_sleep: cover property (m == lin_io_pkg::MODE_FALLBACK_SLEEP);
    c_standby: cover property (m == lin_io_pkg::MODE_STANDBY);
    c_wake: cover property (bus_wake_out);
endmodule
`default_nettype wire

// *** dv/lin_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Far-side bus master: recessive through the pull-up unless told to short the bus.
module lin_master_model
(
    input wire logic sys_clk_in,
    input wire logic hold_dom_in,
    input wire logic bus_wake_in,
    output logic     lin_rx_out,
    output int       wakes_out
);
    initial wakes_out = 0;
    // The bus idles at the pull-up level; dominant only while a fault is commanded.
    assign lin_rx_out = !hold_dom_in;
    // Count wake pulses sent to the master.
    always @(posedge sys_clk_in)
    begin
        if (bus_wake_in === 1'b1)
            wakes_out <= wakes_out + 1;
    end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Self-checking bench for the mode controller.
module testbench;
    logic clk, nrst, rd, wr, hold, cen;
    logic [5:0]  adr;
    logic [31:0] wd, rq;
    logic [7:0]  pin, mtx, adc, fbv, lv;
    wire  [31:0] rdata;
    wire  [7:0]  pout, poe;
    wire  [2:0]  mode;
    wire  wreq, rx, rpin, rpoe, bwake, areset, astart, scan;
    int   fails, n_checks, wakes;
    lin_io_slave_mode_control #(.DOM_TIMEOUT_CYCLES(20), .IDLE_TIMEOUT_CYCLES(40),
        .CYCLIC_DIV(8)) u_lin_io_slave_mode_control (.sys_clk_in(clk), .nrst_in(nrst),
        .clk_en_in(cen), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .lin_rx_in(rx), .io_pin_in(pin), .matrix_value_in(mtx),
        .adc_sample_in(adc), .io_pin_out(pout), .io_pin_oe_out(poe),
        .regulator_control_pin_out(rpin), .regulator_control_pin_oe_out(rpoe),
        .bus_wake_out(bwake), .adc_reset_out(areset), .adc_start_out(astart),
        .matrix_scan_out(scan), .mode_out(mode));
    lin_master_model u_lin_master_model (.sys_clk_in(clk), .hold_dom_in(hold),
        .bus_wake_in(bwake), .lin_rx_out(rx), .wakes_out(wakes));
    // Latch value expected after sleep entry.
    function automatic logic [7:0] exp_latch(input logic sel, input logic [7:0] l, f);
        return sel ? f : l;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // One Avalon cycle; the request is held until the rising edge that samples
    // waitrequest low, read data is taken there, then the request is released.
    // The task returns on the second falling edge after that so registered pin outputs have settled.
    task automatic bus(input logic r, input logic [5:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        rd <= r;
        wr <= !r;
        adr <= a;
        wd <= d;
        pin <= 8'($urandom);
        mtx <= 8'($urandom);
        adc <= 8'($urandom);
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (wreq !== 1'b0 && i < 20);
        if (wreq !== 1'b0)
            fails++;
        rq = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // Event pulse; bus activity rides along only where the idle timer runs.
    task automatic ev(input logic [31:0] b);
        bus(1'b0, 6'h02, b | ((mode[2:1] == 2'b01 || mode == 3'b100) ? 0 : 32'h0000_2000));
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Free-running 125 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = !clk;
    end
    // Watchdog cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end
    // Main sequence.
    initial
    begin
        {nrst, rd, wr, hold, adr, wd, pin, mtx, adc} = '0;
        cen = 1'b1;
        fails = 0;
        n_checks = 0;
        void'($urandom(32'h6355));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk(mode, lin_io_pkg::MODE_CONFIG);
        chk({poe, rpin, rpoe}, 10'h003);
        bus(1'b0, 6'h01, 32'h0000_0020);
        bus(1'b1, 6'h01, 32'h0000_0000);
        chk(rq[7:0], 8'h00);
        ev(32'h0000_0001);
        chk(mode, lin_io_pkg::MODE_NORMAL);
        bus(1'b0, 6'h05, 32'h0000_00FF);
        chk(poe, 8'h00);
        ev(32'h0000_0040);
        chk(poe, 8'hFF);
        ev(32'h0000_0001);
        chk(poe, 8'h00);
        for (int s = 0; s < 2; s++)
        begin
            fbv = $urandom;
            lv = $urandom;
            bus(1'b0, 6'h01, s ? 32'h0000_0020 : 32'h0000_0000);
            bus(1'b0, 6'h03, {24'h0, fbv});
            bus(1'b0, 6'h09, {24'h0, lv});
            bus(1'b0, 6'h04, $urandom);
            ev(32'h0000_0008);
            chk(mode, s ? lin_io_pkg::MODE_FALLBACK_SLEEP : lin_io_pkg::MODE_SLEEP);
            chk({rpoe, areset}, 2'b01);
            bus(1'b1, 6'h09, 32'h0000_0000);
            chk(rq[7:0], exp_latch(s, lv, fbv));
            bus(1'b1, 6'h04, 32'h0000_0000);
            chk(rq[7:0], 8'h00);
            ev(32'h0000_1000);
            chk(mode, lin_io_pkg::MODE_NORMAL);
            chk(wakes, s + 1);
            bus(1'b1, 6'h09, 32'h0000_0000);
            chk(rq[7:0], exp_latch(s, lv, fbv));
        end
        ev(32'h0000_0100);
        lv = adc;
        bus(1'b1, 6'h0C, 32'h0000_0000);
        chk(rq[7:0], lv);
        repeat (60) @(posedge clk);
        @(negedge clk);
        chk(mode, lin_io_pkg::MODE_FALLBACK);
        bus(1'b1, 6'h0A, 32'h0000_0000);
        chk(rq[1], 1'b1);
        bus(1'b1, 6'h0A, 32'h0000_0000);
        chk(rq[1], 1'b0);
        ev(32'h0000_0080);
        chk(mode, lin_io_pkg::MODE_STANDBY);
        chk(rpoe, 1'b1);
        ev(32'h0000_0010);
        chk(mode, lin_io_pkg::MODE_NORMAL);
        chk(pout, fbv);
        // A frozen clock enable stops the idle timer, so normal mode must survive.
        @(posedge clk);
        cen <= 1'b0;
        repeat (50) @(posedge clk);
        cen <= 1'b1;
        @(negedge clk);
        chk(mode, lin_io_pkg::MODE_NORMAL);
        @(posedge clk);
        hold <= 1'b1;
        repeat (40) @(posedge clk);
        hold <= 1'b0;
        @(negedge clk);
        chk(mode, lin_io_pkg::MODE_FALLBACK);
        ev(32'h0000_0080);
        ev(32'h0000_0008);
        chk(mode, lin_io_pkg::MODE_FALLBACK);
        ev(32'h0000_0080);
        ev(32'h0000_0020);
        chk(mode, lin_io_pkg::MODE_FALLBACK);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        ev(32'h0000_0008);
        chk(mode, lin_io_pkg::MODE_FALLBACK);
        ev(32'h0000_0080);
        chk(mode, lin_io_pkg::MODE_CONFIG);
        give_verdict();
    end
endmodule
bind lin_io_slave_mode_control lin_io_chk #(.DOM_TIMEOUT_CYCLES(DOM_TIMEOUT_CYCLES)) u_chk (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_waitrequest_out(avs_waitrequest_out), .lin_rx_in(lin_rx_in),
    .io_pin_oe_out(io_pin_oe_out), .regulator_control_pin_out(regulator_control_pin_out),
    .regulator_control_pin_oe_out(regulator_control_pin_oe_out), .bus_wake_out(bus_wake_out),
    .adc_reset_out(adc_reset_out), .adc_start_out(adc_start_out), .mode_out(mode_out));
`default_nettype wire
